// ---- rtl/cfa_flags.sv ----
/*
 * Condition flag unit, interrupt gate, operand address former and an
 * AXI4-Lite register slave. Assumes one synchronous operation request per
 * cycle at most and an instruction boundary pulse from the sequencer.
 */
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Overflow flag tracks two's complement overflow.
// - Signed branches evaluate the overflow flag.
// - Half-carry set on carry from bit three.
// - Decimal adjust corrects using half-carry and carry.
// - Set interrupt mask blocks maskable interrupts.
// - Mask set after stacking, before handler.
// - No interrupt right after mask clear.
// - Negative flag follows result bit seven.
// - Load or store sets negative from MSB.
// - Zero flag set on all-zero result.
// - Load or store sets zero when empty.
// - Carry on add carry-out or subtract borrow.
// - Bit test, shift, rotate write carry.
// - One linear sixteen-bit address space.
// - Tested operand by mode, target relative.
// - Move decodes source and destination separately.
// - Register-only mode makes no memory access.
// - Relative offset sign-extended, added to PC.
// - Direct address has zero upper byte.
module cfa_flags
    import cfa_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire cfa_req_t req,
    input wire logic boundary,
    input wire logic irq_req,
    output cfa_rsp_t rsp,
    output logic done,
    output logic [7:0] condition_code_reg,
    output logic irq_take,
    input wire logic [AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[7]}}, v};
    endfunction : sext8

    // Every operand, register or port lives in one 16-bit space.
    function automatic logic [15:0] eff_addr(input cfa_mode_t m, input logic [15:0] f,
                                             input logic [15:0] hx);
        case (m)
            DIRECT_MODE: eff_addr = {DIRECT_PAGE, f[7:0]};
            EXTENDED_MODE: eff_addr = f;
            INDEXED_MODE: eff_addr = hx;
            INDEXED8_MODE: eff_addr = hx + {8'h00, f[7:0]};
            INDEXED16_MODE: eff_addr = hx + f;
            default: eff_addr = 16'h0000;
        endcase
    endfunction : eff_addr

    function automatic logic [1:0] neg_zero(input logic [15:0] v, input logic w);
        neg_zero = w ? {v[15], v == 16'h0000} : {v[7], v[7:0] == 8'h00};
    endfunction : neg_zero

    logic [7:0] ccr_q, ccr_d;
    cfa_rsp_t rsp_q, rsp_d;
    logic done_q, done_d, inhibit_q, inhibit_d, irq_take_q, irq_take_d;
    logic [7:0] a8, m8, r8, corr;
    logic cin, nv, wr_fire, wr_ccr;
    logic [8:0] sum9, dif9;
    logic [4:0] half5;
    logic [1:0] nz;
    logic [15:0] res16;
    logic awready_q, awready_d, bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    assign a8 = req.acc[7:0];
    assign m8 = req.opnd[7:0];
    assign cin = (req.op == ADD_CARRY_OP || req.op == SUB_CARRY_OP) && ccr_q[CCR_C];
    assign sum9 = {1'b0, a8} + {1'b0, m8} + {8'h00, cin};
    assign dif9 = {1'b0, a8} - {1'b0, m8} - {8'h00, cin};
    assign half5 = {1'b0, a8[3:0]} + {1'b0, m8[3:0]} + {4'h0, cin};
    assign nv = ccr_q[CCR_N] ^ ccr_q[CCR_V];
    assign wr_fire = awready_q && awvalid && wvalid;
    assign wr_ccr = wr_fire && awaddr == ADDR_CCR && wstrb[0];

    always_comb begin
        ccr_d = ccr_q;
        rsp_d = rsp_q;
        done_d = 1'b0;
        inhibit_d = inhibit_q;
        irq_take_d = 1'b0;
        r8 = 8'h00;
        corr = 8'h00;
        res16 = 16'h0000;
        nz = 2'b00;
        if (wr_ccr) begin
            ccr_d = wdata[7:0] & CCR_WMASK;
        end
        if (boundary) begin
            irq_take_d = irq_req && !ccr_q[CCR_I] && !inhibit_q;
            inhibit_d = 1'b0;
        end
        if (req_valid) begin
            done_d = 1'b1;
            rsp_d.taken = 1'b0;
            rsp_d.src_addr = eff_addr(req.src_mode, req.src_field, req.hx);
            rsp_d.dst_addr = eff_addr(req.dst_mode, req.dst_field, req.hx);
            rsp_d.mem_access = req.src_mode != REGISTER_ONLY_MODE;
            case (req.op)
                ADD_OP, ADD_CARRY_OP: begin
                    r8 = sum9[7:0];
                    ccr_d[CCR_V] = (a8[7] == m8[7]) && (r8[7] != a8[7]);
                    ccr_d[CCR_H] = half5[4];
                    ccr_d[CCR_C] = sum9[8];
                end
                SUB_OP, SUB_CARRY_OP: begin
                    r8 = dif9[7:0];
                    ccr_d[CCR_V] = (a8[7] != m8[7]) && (r8[7] != a8[7]);
                    ccr_d[CCR_C] = dif9[8];
                end
                AND_OP: begin
                    r8 = a8 & m8;
                    ccr_d[CCR_V] = 1'b0;
                end
                LOAD_STORE_OP, MOVE_OP: begin
                    r8 = m8;
                    ccr_d[CCR_V] = 1'b0;
                end
                DECIMAL_ADJUST_OP: begin
                    // Overflow is undefined after the adjust, so it is left alone.
                    if (ccr_q[CCR_H] || a8[3:0] > DAA_LO_LIM) begin
                        corr = DAA_LO_ADD;
                    end
                    if (ccr_q[CCR_C] || a8 > DAA_HI_LIM) begin
                        corr = corr | DAA_HI_ADD;
                        ccr_d[CCR_C] = 1'b1;
                    end
                    r8 = a8 + corr;
                end
                SHIFT_LEFT_OP: begin
                    r8 = {a8[6:0], 1'b0};
                    ccr_d[CCR_C] = a8[7];
                    ccr_d[CCR_V] = r8[7] ^ a8[7];
                end
                ROTATE_RIGHT_OP: begin
                    r8 = {ccr_q[CCR_C], a8[7:1]};
                    ccr_d[CCR_C] = a8[0];
                    ccr_d[CCR_V] = r8[7] ^ a8[0];
                end
                BRANCH_BIT_ZERO_OP, BRANCH_BIT_ONE_OP: begin
                    ccr_d[CCR_C] = m8[req.bit_sel];
                    rsp_d.taken = m8[req.bit_sel] == (req.op == BRANCH_BIT_ONE_OP);
                end
                COMPARE_BRANCH_EQUAL_OP: rsp_d.taken = a8 == m8;
                DECREMENT_BRANCH_NONZERO_OP: begin
                    rsp_d.result = {8'h00, m8 - 8'h01};
                    rsp_d.taken = m8 != 8'h01;
                end
                BRANCH_GREATER_OP: rsp_d.taken = !(ccr_q[CCR_Z] || nv);
                BRANCH_GREATER_EQUAL_OP: rsp_d.taken = !nv;
                BRANCH_LESS_EQUAL_OP: rsp_d.taken = ccr_q[CCR_Z] || nv;
                BRANCH_LESS_OP: rsp_d.taken = nv;
                CLEAR_IRQ_MASK_OP: begin
                    ccr_d[CCR_I] = 1'b0;
                    inhibit_d = ccr_q[CCR_I];
                end
                ACC_TO_FLAGS_OP: begin
                    ccr_d = a8 & CCR_WMASK;
                    inhibit_d = ccr_q[CCR_I] && !a8[CCR_I];
                end
                SET_IRQ_MASK_OP: ccr_d[CCR_I] = 1'b1;
                IRQ_STACKED_OP: ccr_d[CCR_I] = 1'b1;
                default: ;
            endcase
            case (req.op)
                ADD_OP, ADD_CARRY_OP, SUB_OP, SUB_CARRY_OP, AND_OP, DECIMAL_ADJUST_OP,
                SHIFT_LEFT_OP, ROTATE_RIGHT_OP, LOAD_STORE_OP, MOVE_OP: begin
                    res16 = (req.op == LOAD_STORE_OP && req.wide) ? req.opnd : {8'h00, r8};
                    nz = neg_zero(res16, req.op == LOAD_STORE_OP && req.wide);
                    ccr_d[CCR_N] = nz[1];
                    ccr_d[CCR_Z] = nz[0];
                    rsp_d.result = res16;
                end
                default: ; // Flags outside the operation's set hold.
            endcase
            // The target is always relative to the program counter.
            rsp_d.target = rsp_d.taken ? req.pc + sext8(req.rel) : req.pc;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ccr_q <= CCR_RESET;
            rsp_q <= '0;
            done_q <= 1'b0;
            inhibit_q <= 1'b0;
            irq_take_q <= 1'b0;
        end else begin
            ccr_q <= ccr_d;
            rsp_q <= rsp_d;
            done_q <= done_d;
            inhibit_q <= inhibit_d;
            irq_take_q <= irq_take_d;
        end
    end

    // Register slave: ready is a one-cycle pulse so every output stays a flop.

    always_comb begin
        awready_d = !awready_q && !bvalid_q && awvalid && wvalid;
        bvalid_d = bvalid_q && !bready;
        bresp_d = bresp_q;
        arready_d = !arready_q && !rvalid_q && arvalid;
        rvalid_d = rvalid_q && !rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (wr_fire) begin
            bvalid_d = 1'b1;
            bresp_d = (awaddr == ADDR_CCR) ? RESP_OKAY : RESP_SLVERR;
        end
        if (arready_q && arvalid) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            case (araddr)
                ADDR_CCR: rdata_d = {24'h000000, ccr_q};
                ADDR_RES: rdata_d = {rsp_q.src_addr, rsp_q.result};
                ADDR_ADR: rdata_d = {rsp_q.dst_addr, rsp_q.target};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            awready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            awready_q <= awready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign rsp = rsp_q;
    assign done = done_q;
    assign condition_code_reg = ccr_q;
    assign irq_take = irq_take_q;
    assign awready = awready_q;
    assign wready = awready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_mask_cleared;
        req_valid && req.op == CLEAR_IRQ_MASK_OP && ccr_q[CCR_I];
    endsequence
    sequence s_gap;
        (!boundary) [*2];
    endsequence
    sequence s_next_boundary;
        boundary && irq_req;
    endsequence

    AST_OVERFLOW: assert property (req_valid && req.op == ADD_OP |=> ccr_q[CCR_V] ==
        (($past(req.acc[7]) == $past(req.opnd[7])) && (rsp_q.result[7] != $past(req.acc[7]))))
        else $error("Overflow flag wrong after add.");
    AST_SIGNED_BRANCH: assert property (req_valid && req.op == BRANCH_LESS_OP |=>
        rsp_q.taken == ($past(ccr_q[CCR_N]) ^ $past(ccr_q[CCR_V])))
        else $error("Signed branch ignored overflow.");
    AST_HALF_CARRY: assert property (req_valid && req.op == ADD_OP |=> ccr_q[CCR_H] ==
        ((({1'b0, $past(req.acc[3:0])} + {1'b0, $past(req.opnd[3:0])}) & 5'h10) != 5'h00))
        else $error("Half-carry flag wrong.");
    AST_MASKED: assert property (boundary && irq_req && ccr_q[CCR_I] |=> !irq_take_q)
        else $error("Interrupt taken while masked.");
    AST_INHIBIT: assert property (s_mask_cleared ##1 s_gap ##1 s_next_boundary |=>
        !irq_take_q)
        else $error("Interrupt taken right after mask clear.");
    AST_STACKED_MASK: assert property (req_valid && req.op == IRQ_STACKED_OP |=>
        ccr_q[CCR_I])
        else $error("Mask not set after stacking.");
    AST_LOAD_NZ: assert property (req_valid && req.op == LOAD_STORE_OP |=>
        ccr_q[CCR_Z] == ($past(req.wide) ? $past(req.opnd) == 16'h0000
            : $past(req.opnd[7:0]) == 8'h00)
        && ccr_q[CCR_N] == ($past(req.wide) ? $past(req.opnd[15]) : $past(req.opnd[7])))
        else $error("Load flags wrong.");
    AST_BORROW: assert property (req_valid && req.op == SUB_OP |=>
        ccr_q[CCR_C] == ($past(req.opnd[7:0]) > $past(req.acc[7:0])))
        else $error("Borrow flag wrong.");
    AST_DIRECT: assert property (req_valid && req.src_mode == DIRECT_MODE |=>
        rsp_q.src_addr == {DIRECT_PAGE, $past(req.src_field[7:0])})
        else $error("Direct address upper byte not zero.");
    AST_RELATIVE: assert property (done_q && rsp_q.taken |->
        rsp_q.target == $past(req.pc) + {{8{$past(req.rel[7])}}, $past(req.rel)})
        else $error("Branch target wrong.");
    AST_KEEP: assert property (req_valid && req.op == NOP_OP && !wr_ccr |=>
        $stable(ccr_q))
        else $error("Flags changed by a no-flag operation.");
endmodule : cfa_flags

// ---- pkg/cfa_pkg.sv ----
/*
 * Shared constants, operation codes, addressing modes and carriers for the
 * condition flag and addressing unit. Assumes a single 250 MHz clock domain.
 */
package cfa_pkg;
    localparam int CCR_V = 7;
    localparam int CCR_H = 4;
    localparam int CCR_I = 3;
    localparam int CCR_N = 2;
    localparam int CCR_Z = 1;
    localparam int CCR_C = 0;
    localparam logic [7:0] CCR_RESET = 8'h08;
    localparam logic [7:0] CCR_WMASK = 8'h9f;
    localparam logic [3:0] DAA_LO_LIM = 4'h9;
    localparam logic [7:0] DAA_HI_LIM = 8'h99;
    localparam logic [7:0] DAA_LO_ADD = 8'h06;
    localparam logic [7:0] DAA_HI_ADD = 8'h60;
    localparam logic [7:0] DIRECT_PAGE = 8'h00;
    localparam int AXI_AW = 8;
    localparam logic [7:0] ADDR_CCR = 8'h00;
    localparam logic [7:0] ADDR_RES = 8'h04;
    localparam logic [7:0] ADDR_ADR = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [4:0] {
        NOP_OP, ADD_OP, ADD_CARRY_OP, SUB_OP, SUB_CARRY_OP, AND_OP, LOAD_STORE_OP,
        DECIMAL_ADJUST_OP, SHIFT_LEFT_OP, ROTATE_RIGHT_OP, BRANCH_BIT_ZERO_OP,
        BRANCH_BIT_ONE_OP, COMPARE_BRANCH_EQUAL_OP, DECREMENT_BRANCH_NONZERO_OP,
        BRANCH_GREATER_OP, BRANCH_GREATER_EQUAL_OP, BRANCH_LESS_EQUAL_OP,
        BRANCH_LESS_OP, CLEAR_IRQ_MASK_OP, ACC_TO_FLAGS_OP, SET_IRQ_MASK_OP,
        IRQ_STACKED_OP, MOVE_OP
    } cfa_op_t;

    typedef enum logic [2:0] {
        REGISTER_ONLY_MODE, DIRECT_MODE, EXTENDED_MODE, INDEXED_MODE,
        INDEXED8_MODE, INDEXED16_MODE
    } cfa_mode_t;

    typedef struct packed {
        cfa_op_t op;
        logic wide;
        logic [15:0] acc;
        logic [15:0] opnd;
        logic [2:0] bit_sel;
        logic [15:0] pc;
        logic [7:0] rel;
        logic [15:0] hx;
        cfa_mode_t src_mode;
        logic [15:0] src_field;
        cfa_mode_t dst_mode;
        logic [15:0] dst_field;
    } cfa_req_t;

    typedef struct packed {
        logic [15:0] result;
        logic [15:0] src_addr;
        logic [15:0] dst_addr;
        logic [15:0] target;
        logic taken;
        logic mem_access;
    } cfa_rsp_t;
endpackage : cfa_pkg

// ---- tb/cfa_seq_model.sv ----
/*
 * Sequencer-side model that drives instruction boundary pulses and the
 * maskable interrupt request level of the condition flag unit.
 * Assumes the bench requests each boundary with a one-cycle tick.
 */
`timescale 1ns/1ps
module cfa_seq_model
    import cfa_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    input wire logic irq_on,
    output logic boundary,
    output logic irq_req
);
    // Registered, so each boundary follows tick one cycle later and lasts as long as tick does.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            boundary <= 1'b0;
            irq_req <= 1'b0;
        end else begin
            boundary <= tick;
            irq_req <= irq_on;
        end
    end
endmodule : cfa_seq_model

// ---- tb/cfa_flags_tb_top.sv ----
/*
 * Self-checking bench for the condition flag unit: operation, interrupt gate
 * and AXI4-Lite register access. Assumes the 250 MHz clock and async reset.
 */
`timescale 1ns/1ps
module cfa_flags_tb_top
    import cfa_pkg::*;
;
    logic clock, rst, req_valid, tick, irq_on, boundary, irq_req, done, irq_take;
    cfa_req_t req, nx;
    cfa_rsp_t rsp;
    logic [7:0] condition_code_reg, awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int num_errors, checked;

    cfa_flags dut (
        .clock(clock),
        .rst(rst),
        .req_valid(req_valid),
        .req(req),
        .boundary(boundary),
        .irq_req(irq_req),
        .rsp(rsp),
        .done(done),
        .condition_code_reg(condition_code_reg),
        .irq_take(irq_take),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready)
    );
    cfa_seq_model model (
        .clock(clock),
        .rst(rst),
        .tick(tick),
        .irq_on(irq_on),
        .boundary(boundary),
        .irq_req(irq_req)
    );

    always #2 clock = ~clock;

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic cc(input logic [7:0] m, input logic [7:0] e);
        chk({24'h0, condition_code_reg & m}, {24'h0, e}, "ccr");
    endtask : cc

    task automatic op(input cfa_op_t o, input logic [15:0] a, input logic [15:0] b);
        @(posedge clock);
        nx.op = o;
        nx.acc = a;
        nx.opnd = b;
        req <= nx;
        req_valid <= 1'b1;
        @(posedge clock);
        req_valid <= 1'b0;
        #1;
        chk({31'h0, done}, 32'h1, "done");
    endtask : op

    task automatic bnd(input logic e);
        @(posedge clock);
        tick <= 1'b1;
        @(posedge clock);
        tick <= 1'b0;
        @(posedge clock);
        #1;
        chk({31'h0, irq_take}, {31'h0, e}, "irq gate");
    endtask : bnd

    // Each channel holds valid and payload until its own sampled ready.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        logic aw_open;
        logic w_open;
        n = 0;
        aw_open = 1'b1;
        w_open = 1'b1;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (aw_open && awready === 1'b1) begin
                aw_open = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_open && wready === 1'b1) begin
                w_open = 1'b0;
                wvalid <= 1'b0;
            end
        end while ((aw_open || w_open || bvalid !== 1'b1) && n < 50);
        bready <= 1'b0;
        chk({31'h0, n < 50}, 32'h1, "write wait");
        chk({30'h0, bresp}, {30'h0, r}, "bresp");
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (arready !== 1'b1 && n < 50);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        rready <= 1'b0;
        rd = rdata;
        chk({31'h0, n < 50}, 32'h1, "read wait");
        chk({30'h0, rresp}, {30'h0, r}, "rresp");
    endtask : axi_rd

    task automatic br(input cfa_op_t o, input logic [7:0] c, input logic t);
        axi_wr(ADDR_CCR, {24'h0, c}, RESP_OKAY);
        op(o, 16'h0, 16'h0);
        chk({31'h0, rsp.taken}, {31'h0, t}, "taken");
        chk({16'h0, rsp.target}, t ? 32'h0ffe : 32'h1000, "target");
    endtask : br

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        nx = '0;
        tick = 1'b0;
        irq_on = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        num_errors = 0;
        checked = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        irq_on <= 1'b1;
        @(posedge clock);
        #1;
        cc(8'hff, 8'h08);
        bnd(1'b0);
        op(ADD_OP, 16'h007f, 16'h0001);
        cc(8'hff, 8'h9c);
        chk({16'h0, rsp.result}, 32'h0080, "sum");
        op(AND_OP, 16'h00f0, 16'h000f);
        cc(8'hff, 8'h1a);
        op(ADD_OP, 16'h00ff, 16'h0001);
        cc(8'hff, 8'h1b);
        op(SUB_OP, 16'h0000, 16'h0001);
        cc(8'hff, 8'h1d);
        op(ADD_OP, 16'h0019, 16'h0028);
        cc(8'hff, 8'h18);
        op(DECIMAL_ADJUST_OP, 16'h0041, 16'h0000);
        chk({24'h0, rsp.result[7:0]}, 32'h47, "bcd");
        cc(8'h7f, 8'h18);
        op(ADD_OP, 16'h0099, 16'h0001);
        cc(8'hff, 8'h0c);
        op(DECIMAL_ADJUST_OP, 16'h009a, 16'h0000);
        chk({24'h0, rsp.result[7:0]}, 32'h00, "bcd carry");
        cc(8'h7f, 8'h0b);
        op(SHIFT_LEFT_OP, 16'h0080, 16'h0000);
        cc(8'hff, 8'h8b);
        nx.wide = 1'b1;
        op(LOAD_STORE_OP, 16'h8000, 16'h8000);
        cc(8'h7f, 8'h0d);
        op(LOAD_STORE_OP, 16'h0100, 16'h0100);
        cc(8'h7f, 8'h09);
        op(LOAD_STORE_OP, 16'h0000, 16'h0000);
        cc(8'h7f, 8'h0b);
        nx.wide = 1'b0;
        op(NOP_OP, 16'h00ff, 16'h0080);
        cc(8'hff, 8'h0b);
        axi_wr(ADDR_CCR, 32'h0000_00ff, RESP_OKAY);
        axi_rd(ADDR_CCR, RESP_OKAY);
        chk(rd, 32'h0000_009f, "ccr readback");
        axi_wr(ADDR_RES, 32'h0, RESP_SLVERR);
        axi_rd(8'h0c, RESP_SLVERR);
        chk(rd, 32'h0, "unmapped data");
        nx.pc = 16'h1000;
        nx.rel = 8'hfe;
        br(BRANCH_GREATER_OP, 8'h80, 1'b0);
        br(BRANCH_GREATER_EQUAL_OP, 8'h84, 1'b1);
        br(BRANCH_LESS_EQUAL_OP, 8'h80, 1'b1);
        br(BRANCH_LESS_OP, 8'h84, 1'b0);
        nx.bit_sel = 3'd2;
        op(BRANCH_BIT_ONE_OP, 16'h0000, 16'h0004);
        chk({31'h0, rsp.taken}, 32'h1, "bit one");
        cc(8'h01, 8'h01);
        op(BRANCH_BIT_ZERO_OP, 16'h0000, 16'h00fb);
        chk({16'h0, rsp.target}, 32'h0ffe, "bit zero");
        cc(8'h01, 8'h00);
        nx.src_mode = DIRECT_MODE;
        nx.src_field = 16'h1234;
        nx.dst_mode = EXTENDED_MODE;
        nx.dst_field = 16'habcd;
        op(MOVE_OP, 16'h0000, 16'h0000);
        chk({16'h0, rsp.src_addr}, 32'h0034, "direct src");
        chk({16'h0, rsp.dst_addr}, 32'habcd, "ext dst");
        chk({31'h0, rsp.mem_access}, 32'h1, "mem access");
        nx.src_mode = REGISTER_ONLY_MODE;
        nx.dst_mode = REGISTER_ONLY_MODE;
        op(ADD_OP, 16'h0001, 16'h0001);
        chk({31'h0, rsp.mem_access}, 32'h0, "no access");
        op(SET_IRQ_MASK_OP, 16'h0000, 16'h0000);
        op(CLEAR_IRQ_MASK_OP, 16'h0000, 16'h0000);
        bnd(1'b0);
        bnd(1'b1);
        op(IRQ_STACKED_OP, 16'h0000, 16'h0000);
        cc(8'h08, 8'h08);
        bnd(1'b0);
        op(ACC_TO_FLAGS_OP, 16'h0000, 16'h0000);
        bnd(1'b0);
        bnd(1'b1);
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        cc(8'hff, 8'h08);
        bnd(1'b0);
        summarize();
    end

    // The tests need under two hundred cycles; the margin covers every bounded wait.
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        summarize();
    end
endmodule : cfa_flags_tb_top
